// *** design/iar_pkg.sv ***
// constants shared by the insulation alarm relay control block
package iar_pkg;
   // ==================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_THRESH = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   // ==================================================
   // config fields
   localparam int CFG_EXTENDED = 0;
   localparam int CFG_CLOSED = 1;
   localparam int CFG_RETAIN = 2;
   localparam int CFG_OC_DETECT = 3;
   localparam int CFG_INDEP = 4;
   localparam int CFG_W = 5;
   localparam logic [4:0] CONFIG_RESET = 5'h00;
   // ==================================================
   // threshold fields: digits and hysteresis
   localparam int THR_SD_TENS = 0;
   localparam int THR_SD_UNITS = 4;
   localparam int THR_WN_TENS = 8;
   localparam int THR_WN_UNITS = 12;
   localparam int THR_HYST = 16;
   localparam int THR_W = 24;
   localparam logic [23:0] THRESH_RESET = 24'h02_0000;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [3:0] TENS_STEP_KOHM = 4'hA;
   // ==================================================
   // status fields
   localparam int ST_STATE = 0;
   localparam int ST_SD_LAT = 2;
   localparam int ST_WN_LAT = 3;
   localparam int ST_PARAM = 4;
   localparam int ST_DEV = 5;
   localparam int ST_MODE = 6;
   // ==================================================
   // reset wiring codes of the control terminals
   localparam logic [1:0] WIRE_AUTO = 2'h0;
   localparam logic [1:0] WIRE_REMOTE = 2'h1;
   localparam logic [1:0] WIRE_FRONT = 2'h2;
   // ==================================================
   // timing
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int TEST_AC_S = 10;
   localparam int TEST_DC_S = 15;
   localparam int TEST_AC_MS = TEST_AC_S * MS_PER_S;
   localparam int TEST_DC_MS = TEST_DC_S * MS_PER_S;
   // ==================================================
   // operating states, gray along test -> run -> fail
   typedef enum logic [1:0] {
      IAR_TEST = 2'b00,
      IAR_RUN = 2'b01,
      IAR_FAIL = 2'b11
   } iar_state_e;
endpackage

// *** design/iar_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module iar_sync #(
   parameter int W = 1
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic [W-1:0] i_pin,
   output logic [W-1:0] o_level
);
   // ==================================================
   // per bit: the first stage is read only by the second
   for (genvar b = 0; b < W; b++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge i_clock or negedge i_arst_n) begin
         if (!i_arst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            o_level[b] <= 1'b0;
         end else begin
            s1 <= i_pin[b];
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
               o_level[b] <= s3;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** design/iar_core.sv ***
// insulation alarm relay decision and output control
// Behaviour
// - self-test after power-up; closed-circuit relays leave initial state only if fault free
// - self-test ends within 10 s on AC, 15 s with DC components
// - basic variant always uses closed-circuit principle
// - extended variant selects closed or open circuit by switch
// - basic: trips below threshold, recovers above threshold plus hysteresis
// - switch 4 selects combined or independent relay arrangement
// - combined: both relays follow shutdown threshold only
// - independent: each relay follows its own threshold with hysteresis
// - ground open circuit forces shutdown relay, both on extended
// - extended tests measuring inputs for open circuit at start, switch 3
// - test button reruns the measuring-input open-circuit test
// - excessive discharge capacity forces shutdown relay, both on extended
// - on extended, inconsistent settings flag parameter error and force relays to fault
// - autoreset returns relay once fault condition has cleared
// - manual mode holds fault until reset, above threshold plus hysteresis
// - power cycling clears latched fault unless retained
// - terminal wiring selects reset sources; autoreset by default
// - retentive storage restores pre-shutdown fault state after power loss
// - retention without remote-reset link reports parameter error
// - open-circuit principle energises only on fault
// - three lamps show the operating state
// - threshold is tens digit times 10 plus units digit
// - all switches off after reset
`timescale 1ns/1ps
`default_nettype none
module iar_core #(
   parameter int MS_CYCLES = iar_pkg::MS_CYCLES,
   parameter int TEST_AC_MS = iar_pkg::TEST_AC_MS,
   parameter int TEST_DC_MS = iar_pkg::TEST_DC_MS
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [7:0] i_resistance_kohm,
   input wire logic i_selftest_done,
   input wire logic i_selftest_ok,
   input wire logic i_dc_component,
   input wire logic i_ground_open,
   input wire logic i_capacity_high,
   input wire logic i_input_open,
   input wire logic i_test_button,
   input wire logic i_ctrl_link_bc,
   input wire logic [1:0] i_reset_wiring,
   input wire logic i_nv_fault_stored,
   output logic o_shutdown_relay,
   output logic o_warning_relay,
   output logic o_led_run,
   output logic o_led_shutdown,
   output logic o_led_device,
   output logic o_input_test_req,
   output logic o_nv_fault
);
   // ==================================================
   // pin synchronisers
   logic [4:0] pins_s;
   logic btn_s;
   logic link_s;
   logic [1:0] wiring_s;
   logic nv_s;
   iar_sync #(.W(5)) u_sync (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_pin({i_nv_fault_stored, i_reset_wiring, i_ctrl_link_bc,
              i_test_button}),
      .o_level(pins_s)
   );
   assign btn_s = pins_s[0];
   assign link_s = pins_s[1];
   assign wiring_s = pins_s[3:2];
   assign nv_s = pins_s[4];

   logic btn_q;
   logic link_q;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         btn_q <= 1'b0;
         link_q <= 1'b0;
      end else begin
         btn_q <= btn_s;
         link_q <= link_s;
      end
   end

   // ==================================================
   // configuration and thresholds
   logic [iar_pkg::CFG_W-1:0] cfg;
   logic [iar_pkg::THR_W-1:0] thr;
   logic ext;
   logic closed;
   logic retain;
   logic oc_en;
   logic indep;
   assign ext = cfg[iar_pkg::CFG_EXTENDED];
   assign closed = !ext || cfg[iar_pkg::CFG_CLOSED];
   assign retain = ext && cfg[iar_pkg::CFG_RETAIN];
   assign oc_en = ext && cfg[iar_pkg::CFG_OC_DETECT];
   assign indep = ext && cfg[iar_pkg::CFG_INDEP];

   logic [3:0] sd_t;
   logic [3:0] sd_u;
   logic [3:0] wn_t;
   logic [3:0] wn_u;
   logic [7:0] hyst;
   assign sd_t = thr[iar_pkg::THR_SD_TENS +: 4];
   assign sd_u = thr[iar_pkg::THR_SD_UNITS +: 4];
   assign wn_t = thr[iar_pkg::THR_WN_TENS +: 4];
   assign wn_u = thr[iar_pkg::THR_WN_UNITS +: 4];
   assign hyst = thr[iar_pkg::THR_HYST +: 8];

   logic [8:0] thr_sd;
   logic [8:0] thr_wn;
   logic [8:0] thr_k2;
   logic [8:0] res;
   assign thr_sd = 9'(sd_t * iar_pkg::TENS_STEP_KOHM) + 9'(sd_u);
   assign thr_wn = 9'(wn_t * iar_pkg::TENS_STEP_KOHM) + 9'(wn_u);
   assign thr_k2 = indep ? thr_wn : thr_sd;
   assign res = 9'(i_resistance_kohm);

   logic under_sd;
   logic under_wn;
   logic recov_sd;
   logic recov_wn;
   assign under_sd = res < thr_sd;
   assign under_wn = res < thr_k2;
   assign recov_sd = 10'(res) > 10'(thr_sd) + 10'(hyst);
   assign recov_wn = 10'(res) > 10'(thr_k2) + 10'(hyst);

   // ==================================================
   // device faults and parameter checks
   logic digit_bad;
   logic param_err;
   logic dev_fault;
   assign digit_bad = (sd_t > iar_pkg::DIGIT_MAX)
      || (sd_u > iar_pkg::DIGIT_MAX) || (wn_t > iar_pkg::DIGIT_MAX)
      || (wn_u > iar_pkg::DIGIT_MAX);
   assign param_err = ext && (digit_bad || (indep && thr_wn < thr_sd)
      || (retain && !link_s));
   assign dev_fault = i_ground_open || i_capacity_high
      || (oc_en && i_input_open) || param_err;

   // ==================================================
   // reset sources
   logic auto_eff;
   logic btn_rise;
   logic remote_evt;
   logic reset_evt;
   // retention keeps the fault until an operator reset
   assign auto_eff = (wiring_s == iar_pkg::WIRE_AUTO) && !retain;
   assign btn_rise = btn_s && !btn_q;
   // remote button is normally closed: opening the link is the press
   assign remote_evt = link_q && !link_s
      && (wiring_s == iar_pkg::WIRE_REMOTE || retain);
   assign reset_evt = btn_rise || remote_evt;

   // ==================================================
   // millisecond divider and self-test timer
   logic [$clog2(MS_CYCLES)-1:0] div_cnt;
   logic ms_tick;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_cnt <= '0;
         ms_tick <= 1'b0;
      end else if (div_cnt == ($clog2(MS_CYCLES))'(MS_CYCLES - 1)) begin
         div_cnt <= '0;
         ms_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 1'b1;
         ms_tick <= 1'b0;
      end
   end

   iar_pkg::iar_state_e state;
   logic [15:0] ms_cnt;
   logic [15:0] test_limit;
   logic timeout;
   assign test_limit = i_dc_component ? 16'(TEST_DC_MS)
      : 16'(TEST_AC_MS);
   assign timeout = ms_cnt >= test_limit;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ms_cnt <= '0;
      end else if (state != iar_pkg::IAR_TEST) begin
         ms_cnt <= '0;
      end else if (ms_tick && !timeout) begin
         ms_cnt <= ms_cnt + 1'b1;
      end
   end

   // ==================================================
   // operating state
   logic start;
   assign start = state == iar_pkg::IAR_TEST && i_selftest_done
      && i_selftest_ok && !dev_fault && !timeout;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= iar_pkg::IAR_TEST;
      end else begin
         unique case (state)
            iar_pkg::IAR_TEST: begin
               if (start) begin
                  state <= iar_pkg::IAR_RUN;
               end else if (timeout || i_selftest_done) begin
                  state <= iar_pkg::IAR_FAIL;
               end
            end
            iar_pkg::IAR_RUN: begin
               state <= iar_pkg::IAR_RUN;
            end
            iar_pkg::IAR_FAIL: begin
               // the front button retries the self-test
               if (btn_rise) begin
                  state <= iar_pkg::IAR_TEST;
               end
            end
            default: begin
               state <= iar_pkg::IAR_TEST;
            end
         endcase
      end
   end

   // ==================================================
   // fault latches; a new trip wins over a reset
   logic sd_lat;
   logic wn_lat;
   logic run;
   assign run = state == iar_pkg::IAR_RUN;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sd_lat <= 1'b0;
         wn_lat <= 1'b0;
      end else if (start) begin
         sd_lat <= retain && nv_s;
         wn_lat <= retain && nv_s;
      end else if (run) begin
         if (under_sd || dev_fault) begin
            sd_lat <= 1'b1;
         end else if (recov_sd && (auto_eff || reset_evt)) begin
            sd_lat <= 1'b0;
         end
         if (under_wn || (ext && dev_fault)) begin
            wn_lat <= 1'b1;
         end else if (recov_wn && (auto_eff || reset_evt)) begin
            wn_lat <= 1'b0;
         end
      end
   end

   // ==================================================
   // relay drive, lamps and side requests
   logic f_sd;
   logic f_wn;
   assign f_sd = state == iar_pkg::IAR_FAIL || sd_lat;
   assign f_wn = state == iar_pkg::IAR_FAIL || wn_lat;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_shutdown_relay <= 1'b0;
         o_warning_relay <= 1'b0;
      end else if (state == iar_pkg::IAR_TEST) begin
         o_shutdown_relay <= 1'b0;
         o_warning_relay <= 1'b0;
      end else begin
         o_shutdown_relay <= closed ? !f_sd : f_sd;
         o_warning_relay <= ext && (closed ? !f_wn : f_wn);
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_led_run <= 1'b0;
         o_led_shutdown <= 1'b0;
         o_led_device <= 1'b0;
         o_nv_fault <= 1'b0;
      end else begin
         o_led_run <= run;
         o_led_shutdown <= sd_lat || wn_lat;
         o_led_device <= state == iar_pkg::IAR_FAIL || dev_fault;
         o_nv_fault <= sd_lat || wn_lat;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_input_test_req <= 1'b0;
      end else begin
         o_input_test_req <= oc_en && (start || (run && btn_rise));
      end
   end

   // ==================================================
   // apb slave, one wait state per access
   logic hit;
   logic acc;
   assign acc = i_psel && i_penable && !o_pready;
   assign hit = i_paddr == iar_pkg::ADDR_CONFIG
      || i_paddr == iar_pkg::ADDR_THRESH || i_paddr == iar_pkg::ADDR_STATUS;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg <= iar_pkg::CONFIG_RESET;
         thr <= iar_pkg::THRESH_RESET;
      end else if (acc && i_pwrite) begin
         if (i_paddr == iar_pkg::ADDR_CONFIG) begin
            cfg <= i_pwdata[iar_pkg::CFG_W-1:0];
         end
         if (i_paddr == iar_pkg::ADDR_THRESH) begin
            thr <= i_pwdata[iar_pkg::THR_W-1:0];
         end
      end
   end

   logic [31:0] status;
   always_comb begin
      status = '0;
      status[iar_pkg::ST_STATE +: 2] = state;
      status[iar_pkg::ST_SD_LAT] = sd_lat;
      status[iar_pkg::ST_WN_LAT] = wn_lat;
      status[iar_pkg::ST_PARAM] = param_err;
      status[iar_pkg::ST_DEV] = dev_fault;
      status[iar_pkg::ST_MODE +: 2] = wiring_s;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else begin
         o_pready <= acc;
         o_pslverr <= acc && !hit;
         if (acc && !i_pwrite) begin
            unique case (i_paddr)
               iar_pkg::ADDR_CONFIG: o_prdata <= 32'(cfg);
               iar_pkg::ADDR_THRESH: o_prdata <= 32'(thr);
               iar_pkg::ADDR_STATUS: o_prdata <= status;
               default: o_prdata <= '0;
            endcase
         end
      end
   end

   // ==================================================
   // checks
   test_hold_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      state == iar_pkg::IAR_TEST |=> !o_shutdown_relay && !o_warning_relay)
      else $error("relay left initial state during self-test");
   test_time_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      state == iar_pkg::IAR_TEST && timeout && !start
      |=> state == iar_pkg::IAR_FAIL)
      else $error("self-test overran its time");
   basic_closed_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      run && !ext && !sd_lat |=> o_shutdown_relay)
      else $error("basic variant not energised when healthy");
   open_circuit_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      run && ext && !cfg[iar_pkg::CFG_CLOSED] && !sd_lat
      |=> !o_shutdown_relay)
      else $error("open-circuit relay energised without fault");
   under_trip_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      run && under_sd |=> sd_lat ##1 o_shutdown_relay != closed)
      else $error("undershoot did not trip shutdown relay");
   combined_k2_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      run && ext && !indep && under_sd |=> wn_lat)
      else $error("combined warning relay ignored shutdown threshold");
   ground_trip_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      run && ext && i_ground_open |=> sd_lat && wn_lat)
      else $error("ground open did not force both relays");
   param_trip_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      run && ext && indep && thr_wn < thr_sd |=> sd_lat)
      else $error("parameter error did not force fault");
   auto_clear_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      run && auto_eff && recov_sd && !dev_fault |=> !sd_lat)
      else $error("autoreset did not release shutdown relay");
   manual_hold_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      run && sd_lat && !auto_eff && !reset_evt |=> sd_lat)
      else $error("manual mode released without reset");
   retest_a: assert property (
      @(posedge i_clock) disable iff (!i_arst_n)
      run && oc_en && btn_rise |=> o_input_test_req)
      else $error("test button did not rerun input test");
endmodule
`default_nettype wire

// *** verif/iar_field_model.sv ***
// field-side model: front-end self-test and input-test request counter
`timescale 1ns/1ps
`default_nettype none
module iar_field_model #(
   parameter int DELAY = 6
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_go,
   input wire logic i_req,
   output logic o_done,
   output logic o_ok,
   output int o_req_count
);
   int cnt;
   // done stays low until told, so a silent front end can be modelled
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt <= 0;
         o_done <= 1'b0;
      end else if (i_go && cnt < DELAY) begin
         cnt <= cnt + 1;
      end else if (i_go) begin
         o_done <= 1'b1;
      end
   end
   assign o_ok = o_done;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_req_count <= 0;
      end else if (i_req) begin
         o_req_count <= o_req_count + 1;
      end
   end
endmodule
`default_nettype wire

// *** verif/insulation_alarm_relay_control_tb_top.sv ***
// self-checking bench for the insulation alarm relay control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checks_done++; \
   if ((g) !== (e)) begin fail_count++; \
   $display("mismatch at %0t: %s", $time, m); end end
module insulation_alarm_relay_control_tb_top;
   logic i_clock = 1'b0;
   logic i_arst_n = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er;
   logic [7:0] res = 8'hC8;
   logic dc = 1'b0, gnd = 1'b0, cap = 1'b0, btn = 1'b0;
   logic link = 1'b1, go = 1'b0;
   logic iopen = 1'b0, nv = 1'b0;
   logic [1:0] wiring = 2'h0;
   logic sd_rel, wn_rel, led_run, led_sd, led_dev, treq, nv_f;
   logic done, ok;
   logic [4:0] cfg;
   logic [3:0] sdt, sdu, wnt, wnu;
   int reqs, fail_count = 0, checks_done = 0, cyc = 0;
   int seed = 32'h14f3, hy = 2, lim;
   bit m_sd, m_wn;
   iar_core #(.MS_CYCLES(4), .TEST_AC_MS(20), .TEST_DC_MS(30)) iar_core_inst (
      .i_clock(i_clock), .i_arst_n(i_arst_n), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_resistance_kohm(res),
      .i_selftest_done(done), .i_selftest_ok(ok), .i_dc_component(dc),
      .i_ground_open(gnd), .i_capacity_high(cap), .i_input_open(iopen),
      .i_test_button(btn), .i_ctrl_link_bc(link),
      .i_reset_wiring(wiring), .i_nv_fault_stored(nv),
      .o_shutdown_relay(sd_rel), .o_warning_relay(wn_rel),
      .o_led_run(led_run), .o_led_shutdown(led_sd),
      .o_led_device(led_dev), .o_input_test_req(treq), .o_nv_fault(nv_f));
   iar_field_model iar_field_model_inst (
      .i_clock(i_clock), .i_arst_n(i_arst_n), .i_go(go), .i_req(treq),
      .o_done(done), .o_ok(ok), .o_req_count(reqs));
   always #12.5 i_clock = ~i_clock;
   // ==================================================
   // verdict and hang guard
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   // ==================================================
   // apb master
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge i_clock);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      pen <= 1'b1;
      // a silent slave is caught by the bench timeout, not here
      do begin
         @(posedge i_clock);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // ==================================================
   // reference model of latches and relays
   task automatic model(input bit press);
      bit ext, cl, ind, dev, man;
      int ts, tw;
      ext = cfg[0];
      cl = ext ? cfg[1] : 1'b1;
      ind = ext & cfg[4];
      ts = sdt * 10 + sdu;
      tw = ind ? wnt * 10 + wnu : ts;
      dev = gnd | cap | (ext & cfg[3] & iopen) | (ind & (tw < ts));
      // retention turns autoreset off
      man = ((wiring != 2'h0) | (ext & cfg[2])) & !press;
      // a trip wins over a reset in the same step
      if (res < ts || dev) m_sd = 1'b1;
      else if (!man && res > ts + hy) m_sd = 1'b0;
      if (res < tw || dev) m_wn = 1'b1;
      else if (!man && res > tw + hy) m_wn = 1'b0;
      `CHK(sd_rel, cl ? ~m_sd : m_sd, "shutdown relay")
      `CHK(wn_rel, ext & (cl ? ~m_wn : m_wn), "warning relay")
      `CHK({led_sd, nv_f}, {2{m_sd | m_wn}}, "fault store")
   endtask
   task automatic step(input int r, input bit g, input bit c);
      res <= r[7:0];
      gnd <= g;
      cap <= c;
      repeat (10) @(posedge i_clock);
      model(1'b0);
   endtask
   // remote button is normally closed, so opening the link is a press
   task automatic press(input bit remote);
      if (remote) link <= 1'b0;
      else btn <= 1'b1;
      repeat (8) @(posedge i_clock);
      link <= 1'b1;
      btn <= 1'b0;
      repeat (8) @(posedge i_clock);
      model(1'b1);
   endtask
   task automatic pwr_cycle(input logic [1:0] wcode);
      go <= 1'b0;
      wiring <= wcode;
      res <= 8'hC8;
      i_arst_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_arst_n <= 1'b1;
      m_sd = 1'b0;
      m_wn = 1'b0;
   endtask
   task automatic start(input logic [4:0] c, input logic [15:0] t,
                        input logic [1:0] wcode);
      int n;
      pwr_cycle(wcode);
      // a stored fault comes back only with retention on
      m_sd = c[0] & c[2] & nv;
      m_wn = m_sd;
      cfg = c;
      {wnu, wnt, sdu, sdt} = t;
      apb(1'b1, iar_pkg::ADDR_CONFIG, {27'h0, c});
      apb(1'b1, iar_pkg::ADDR_THRESH, {16'h0002, t});
      `CHK(sd_rel, 1'b0, "relay left rest during test")
      go <= 1'b1;
      n = 0;
      while (led_run !== 1'b1 && n < 200) begin
         @(posedge i_clock);
         n++;
      end
      `CHK(led_run, 1'b1, "run not reached")
      repeat (4) @(posedge i_clock);
      model(1'b0);
   endtask
   // ==================================================
   // scenarios
   initial begin
      pwr_cycle(2'h0);
      apb(1'b0, iar_pkg::ADDR_CONFIG, 32'h0);
      `CHK(rd, {27'h0, iar_pkg::CONFIG_RESET}, "config reset")
      apb(1'b0, iar_pkg::ADDR_THRESH, 32'h0);
      `CHK(rd, 32'h0002_0000, "thresh reset")
      apb(1'b0, 8'h0C, 32'h0);
      `CHK({er, rd}, 33'h1_0000_0000, "unmapped read")
      $display("test reset values done");
      for (int w = 1; w < 3; w++) begin
         start(5'h00, 16'h0052, w[1:0]);
         step(10, 1'b0, 1'b0);
         step(100, 1'b0, 1'b0);
         press(w == 1);
      end
      step(10, 1'b0, 1'b0);
      $display("test manual reset done");
      start(5'h00, 16'h0052, 2'h0);
      `CHK(sd_rel, 1'b1, "power cycle keeps fault")
      for (int k = 0; k < 3; k++) step(30 + ($random(seed) & 8'h7F), 0, 0);
      step(24, 1'b0, 1'b0);
      step(26, 1'b0, 1'b0);
      step(28, 1'b0, 1'b0);
      step(80, 1'b1, 1'b0);
      step(80, 1'b0, 1'b0);
      step(80, 1'b0, 1'b1);
      step(80, 1'b0, 1'b0);
      `CHK(reqs, 0, "input test in basic variant")
      $display("test basic variant done");
      start(5'h01, 16'h0503, 2'h0);
      step(40, 1'b0, 1'b0);
      step(25, 1'b0, 1'b0);
      step(40, 1'b0, 1'b0);
      $display("test combined open circuit done");
      start(5'h1B, 16'h0402, 2'h0);
      `CHK(reqs, 1, "input test at start")
      step(35, 1'b0, 1'b0);
      step(15, 1'b0, 1'b0);
      step(50, 1'b0, 1'b0);
      press(1'b0);
      `CHK(reqs, 2, "input test on button")
      iopen <= 1'b1;
      step(50, 1'b0, 1'b0);
      iopen <= 1'b0;
      step(50, 1'b0, 1'b0);
      wnt = 4'h1;
      apb(1'b1, iar_pkg::ADDR_THRESH, 32'h0002_0102);
      step(50, 1'b0, 1'b0);
      apb(1'b0, iar_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[iar_pkg::ST_PARAM], 1'b1, "parameter error flag")
      $display("test independent done");
      nv <= 1'b1;
      start(5'h07, 16'h0503, 2'h0);
      nv <= 1'b0;
      step(80, 1'b0, 1'b0);
      press(1'b0);
      link <= 1'b0;
      repeat (8) @(posedge i_clock);
      apb(1'b0, iar_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[iar_pkg::ST_PARAM], 1'b1, "retain without link")
      link <= 1'b1;
      $display("test retained fault done");
      for (int k = 0; k < 2; k++) begin
         dc <= k[0];
         lim = k ? 120 : 80;
         pwr_cycle(2'h0);
         repeat (lim - 10) @(posedge i_clock);
         apb(1'b0, iar_pkg::ADDR_STATUS, 32'h0);
         `CHK(rd[1:0], iar_pkg::IAR_TEST, "left test too early")
         repeat (20) @(posedge i_clock);
         apb(1'b0, iar_pkg::ADDR_STATUS, 32'h0);
         `CHK(rd[1:0], iar_pkg::IAR_FAIL, "test limit ignored")
         `CHK({led_run, led_dev, sd_rel}, 3'b010, "fail outputs")
      end
      $display("test self-test limit done");
      give_verdict();
   end
endmodule
`default_nettype wire
